// ===== include/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// register offsets
`define PCR_ADDR_BOOT 8'h29
`define PCR_ADDR_POLARITY 8'h2A
`define PCR_ADDR_SEQ 8'h2B
`define PCR_ADDR_WDT 8'h2C
`define PCR_ADDR_KEY 8'h2D
`define PCR_ADDR_SHORT 8'h2E
`define PCR_ADDR_BC_ALL 8'h31
`define PCR_ADDR_BC_REF 8'h32
`define PCR_ADDR_BC_PROV 8'h33

// reset values and writable bits
`define PCR_POL_RESET 8'hE0
`define PCR_POL_WMASK 8'hE1
`define PCR_SEQ_RESET 8'h00
`define PCR_SEQ_WMASK 8'h03
`define PCR_WDT_RESET 8'h20
`define PCR_WDT_WMASK 8'h7F
`define PCR_WDT_MIN 7'h01
`define PCR_KEY_RESET 8'h40
`define PCR_KEY_WMASK 8'h5F
`define PCR_ZERO8 8'h00

// field positions
`define PCR_BIT_BOOT_PAIR 0
`define PCR_BIT_REQ3_POL 7
`define PCR_BIT_REQ2_POL 6
`define PCR_BIT_REQ1_EDGE 5
`define PCR_BIT_REQ3_LEVEL 0
`define PCR_BIT_CMP_MASK 0
`define PCR_BIT_KEY_FLAG 7
`define PCR_BIT_LONG_SEL 6
`define PCR_KPD_MSB 4
`define PCR_WDT_MSB 6
`define PCR_CMD_MSB 1
`define PCR_BIT_SHORT7 2
`define PCR_BIT_SHORT5 1
`define PCR_BIT_SHORTO 0

// timing
`define PCR_CLK_PERIOD_NS 25
`define PCR_MS_NS 1000000
`define PCR_MS_PER_S 1000
`define PCR_KEY_STEP_MS 14'h0032
`define PCR_LONG_SHORT_MS 14'h0FA0
`define PCR_LONG_LONG_MS 14'h1F40
`define PCR_VLOW_STEP_MS 14'h0028
`define PCR_VLOW_BASE_MS 14'h0019
`define PCR_TIMER_W 14

// resources: 0-1 reference, 2-18 providers, 19-26 clocks and resets
`define PCR_NRES 27
`define PCR_REF_MASK 27'h0000003
`define PCR_PROV_MASK 27'h007FFFC

`endif

// ===== include/pcr_pkg.sv
package pcr_pkg;

    // applied resource state
    typedef enum logic [1:0] {
        PCR_RES_OFF = 2'b00,
        PCR_RES_ON = 2'b01,
        PCR_RES_SLEEP = 2'b11
    } pcr_res_state_t;

    // watchdog sequencing
    typedef enum logic [1:0] {
        PCR_WD_HOLD = 2'b00,
        PCR_WD_RUN = 2'b01,
        PCR_WD_OFF = 2'b10
    } pcr_wd_state_t;

    // two-bit state command; 10 is a second spelling of off
    function automatic pcr_res_state_t pcr_decode(input logic [1:0] cmd);
        pcr_res_state_t s;
        s = PCR_RES_OFF;
        unique case (cmd)
            2'b01: s = PCR_RES_ON;
            2'b11: s = PCR_RES_SLEEP;
            2'b00, 2'b10: s = PCR_RES_OFF;
        endcase
        return s;
    endfunction

endpackage

// ===== rtl/pcr_tick_gen.sv
`timescale 1ns/1ps
module pcr_tick_gen #(
    parameter int MS_CYCLES = 40000,
    parameter int MS_PER_S = 1000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // enables
    output logic ms_tick_o,
    output logic sec_tick_o
);
    localparam int CW = $clog2(MS_CYCLES);
    localparam int SW = $clog2(MS_PER_S);

    logic [CW-1:0] cyc;
    logic [SW-1:0] ms;
    wire cyc_wrap = (cyc == CW'(MS_CYCLES - 1));
    wire ms_wrap = (ms == SW'(MS_PER_S - 1));

    // free-running dividers stand in for the always-on slow clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc <= '0;
            ms <= '0;
            ms_tick_o <= 1'b0;
            sec_tick_o <= 1'b0;
        end else begin
            cyc <= cyc_wrap ? '0 : cyc + CW'(1);
            ms_tick_o <= cyc_wrap;
            sec_tick_o <= cyc_wrap && ms_wrap;
            if (cyc_wrap) begin
                ms <= ms_wrap ? '0 : ms + SW'(1);
            end
        end
    end
endmodule

// ===== rtl/pcr_hold_timer.sv
`timescale 1ns/1ps
module pcr_hold_timer #(
    parameter int CW = 14
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic tick_i,
    input wire logic active_i,
    input wire logic [CW-1:0] limit_i,
    // result
    output logic fire_o
);
    logic [CW-1:0] count;
    wire reach = tick_i && (count == limit_i - CW'(1));

    // counts ms while the condition holds; fires once per hold
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
            fire_o <= 1'b0;
        end else begin
            fire_o <= active_i && reach;
            if (!active_i) begin
                count <= '0;
            end else if (tick_i && count < limit_i) begin
                count <= count + CW'(1);
            end
        end
    end
endmodule

// ===== rtl/pcr_regs.sv
// What this block does
// R1: cut power after the low-supply delay, accurate to ten milliseconds.
// R2: boot status loads only on the no-supply to wait-on move.
// R3: boot bit 0 shows threshold pair: 0 high values, 1 low values.
// R4: request 3 and 2 resources active when input equals polarity bit.
// R5: request 1 wakes on falling edge if bit 5 is 0, else rising.
// R6: host sets polarity bits before unmasking request events.
// R7: comparator mask 0 needs high threshold; 1 starts above low threshold.
// R8: seven-bit watchdog timeout in seconds, 1 to 127, reset 32.
// R9: writing zero to the watchdog field stores one.
// R10: watchdog held at timeout during reset output low, counts after release.
// R11: watchdog expiry starts the switch-off transition.
// R12: host rewrites the watchdog register periodically before expiry.
// R13: one-time-programmed bit disables the watchdog entirely.
// R14: button held low past duration sets bit 7; read clears it.
// R15: long-hold select bit: 0 four seconds, 1 eight seconds, resets 1.
// R16: duration field in 50 ms steps, codes 0 and 1 both 50 ms.
// R17: short flags per regulator group, any write clears them.
// R18: broadcast command: 00 off, 01 on, 10 off, 11 sleep.
// R19: broadcast-all reaches only resources whose group membership selects them.
// R20: resources take group or own commands; readback shows applied command.
// R21: reference broadcast reaches only bias and clock-supply resources.
// R22: provider broadcast reaches only regulators and external enables.
// R23: second and millisecond ticks come from the slow always-on timebase; here dividers of REF_CLK_I stand in for it.
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_regs
    import pcr_pkg::*;
#(
    parameter int MS_CYCLES = `PCR_MS_NS / `PCR_CLK_PERIOD_NS,
    parameter int MS_PER_S = `PCR_MS_PER_S,
    parameter int NRES = `PCR_NRES,
    parameter logic [NRES-1:0] REF_MASK = `PCR_REF_MASK,
    parameter logic [NRES-1:0] PROV_MASK = `PCR_PROV_MASK
) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // boot straps
    input wire logic BOOT_LOAD_I,
    input wire logic [2:0] BOOT_STRAP_I,
    // power requests
    input wire logic POWER_REQUEST_IN1_I,
    input wire logic POWER_REQUEST_IN2_I,
    input wire logic POWER_REQUEST_IN3_I,
    output logic REQUEST1_WAKE_O,
    output logic REQUEST2_ACTIVE_O,
    output logic REQUEST3_ACTIVE_O,
    output logic REQUEST3_LEVEL_SELECT_O,
    // start comparators
    input wire logic VSYS_ABOVE_HIGH_I,
    input wire logic VSYS_ABOVE_LOW_I,
    output logic START_ALLOWED_O,
    // watchdog
    input wire logic POWER_ON_RESET_OUT_N_I,
    input wire logic WATCHDOG_DISABLE_I,
    output logic SWITCH_OFF_TRANSITION_O,
    // power button
    input wire logic POWER_BUTTON_IN_I,
    output logic LONG_HOLD_O,
    // low supply
    input wire logic VSYS_LOW_I,
    input wire logic [5:0] VSYS_LOW_DELAY_I,
    output logic POWER_CUT_O,
    // regulator shorts
    input wire logic SHORT_REG_SEVEN_I,
    input wire logic SHORT_REG_FIVE_I,
    input wire logic SHORT_OTHER_I,
    // resources
    input wire logic [NRES-1:0] GROUP_MEMBER_I,
    input wire logic [NRES-1:0] RES_OWN_WR_I,
    input wire logic [1:0] RES_OWN_CMD_I,
    output logic [2*NRES-1:0] RES_STATE_O
);
    localparam int TW = `PCR_TIMER_W;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic [2:0] boot_status;
    logic [7:0] pol_cfg, seq_cfg, wdt_cfg, key_cfg;
    logic key_flag, req1_prev;
    logic [2:0] short_flags;
    logic ms_tick, sec_tick, key_fire, long_fire, vlow_fire;
    pcr_wd_state_t wd_state, next_wd_state;
    logic [6:0] wd_count;

    // register strobes
    wire rd_boot = REG_RD_I && REG_ADDR_I == `PCR_ADDR_BOOT;
    wire rd_key = REG_RD_I && REG_ADDR_I == `PCR_ADDR_KEY;
    wire wr_pol = REG_WR_I && REG_ADDR_I == `PCR_ADDR_POLARITY;
    wire wr_seq = REG_WR_I && REG_ADDR_I == `PCR_ADDR_SEQ;
    wire wr_wdt = REG_WR_I && REG_ADDR_I == `PCR_ADDR_WDT;
    wire wr_key = REG_WR_I && REG_ADDR_I == `PCR_ADDR_KEY;
    wire wr_short = REG_WR_I && REG_ADDR_I == `PCR_ADDR_SHORT;
    wire wr_all = REG_WR_I && REG_ADDR_I == `PCR_ADDR_BC_ALL;
    wire wr_ref = REG_WR_I && REG_ADDR_I == `PCR_ADDR_BC_REF;
    wire wr_prov = REG_WR_I && REG_ADDR_I == `PCR_ADDR_BC_PROV;

    // zero is not a legal timeout, so it is stored as one
    wire [6:0] wdt_wr_val = REG_WDATA_I[`PCR_WDT_MSB:0];
    wire [6:0] wdt_new = (wdt_wr_val == 7'h00) ? `PCR_WDT_MIN : wdt_wr_val; // [R9]
    wire [6:0] wdt_field = wdt_cfg[`PCR_WDT_MSB:0]; // [R8]

    // readback; write-only and unmapped offsets read zero
    wire [7:0] rd_data =
        (REG_ADDR_I == `PCR_ADDR_BOOT) ? {5'h00, boot_status} :
        (REG_ADDR_I == `PCR_ADDR_POLARITY) ? pol_cfg :
        (REG_ADDR_I == `PCR_ADDR_SEQ) ? seq_cfg :
        (REG_ADDR_I == `PCR_ADDR_WDT) ? wdt_cfg :
        (REG_ADDR_I == `PCR_ADDR_KEY) ? {key_flag, key_cfg[6:0]} :
        (REG_ADDR_I == `PCR_ADDR_SHORT) ? {5'h00, short_flags} : `PCR_ZERO8;

    // timer limits in milliseconds
    wire [4:0] kpd_code = key_cfg[`PCR_KPD_MSB:0];
    wire [4:0] kpd_eff = (kpd_code == 5'h00) ? 5'h01 : kpd_code; // [R16]
    wire [TW-1:0] key_limit = TW'(kpd_eff) * `PCR_KEY_STEP_MS; // [R16]
    wire [TW-1:0] long_limit = key_cfg[`PCR_BIT_LONG_SEL] ? `PCR_LONG_LONG_MS : `PCR_LONG_SHORT_MS; // [R15]
    // centre of the 20..30 ms window keeps the cut within 10 ms
    wire [TW-1:0] vlow_limit = TW'(VSYS_LOW_DELAY_I) * `PCR_VLOW_STEP_MS + `PCR_VLOW_BASE_MS; // [R1]

    // request and start conditions
    wire req1_edge = pol_cfg[`PCR_BIT_REQ1_EDGE];
    wire req1_wake = req1_edge ? (POWER_REQUEST_IN1_I && !req1_prev)
                               : (!POWER_REQUEST_IN1_I && req1_prev); // [R5]
    wire high_ok = seq_cfg[`PCR_BIT_CMP_MASK] || VSYS_ABOVE_HIGH_I; // [R7]
    wire bcast_hit_any = wr_all || wr_ref || wr_prov;
    pcr_res_state_t bcast_state;
    assign bcast_state = pcr_decode(REG_WDATA_I[`PCR_CMD_MSB:0]); // [R18]

    ////////////////////////////////////////////////////////////////////////
    // timebase and hold timers
    pcr_tick_gen #(.MS_CYCLES(MS_CYCLES), .MS_PER_S(MS_PER_S)) u_tick ( // [R23]
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .ms_tick_o(ms_tick), .sec_tick_o(sec_tick));
    pcr_hold_timer #(.CW(TW)) u_key (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .tick_i(ms_tick),
        .active_i(!POWER_BUTTON_IN_I), .limit_i(key_limit), .fire_o(key_fire));
    pcr_hold_timer #(.CW(TW)) u_long (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .tick_i(ms_tick),
        .active_i(!POWER_BUTTON_IN_I), .limit_i(long_limit), .fire_o(long_fire));
    pcr_hold_timer #(.CW(TW)) u_vlow (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .tick_i(ms_tick),
        .active_i(VSYS_LOW_I), .limit_i(vlow_limit), .fire_o(vlow_fire));

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            boot_status <= 3'h0;
            pol_cfg <= `PCR_POL_RESET;
            seq_cfg <= `PCR_SEQ_RESET;
            wdt_cfg <= `PCR_WDT_RESET;
            key_cfg <= `PCR_KEY_RESET;
        end else begin
            if (BOOT_LOAD_I) begin
                boot_status <= BOOT_STRAP_I; // [R2] [R3]
            end
            if (wr_pol) begin
                pol_cfg <= REG_WDATA_I & `PCR_POL_WMASK; // [R4] [R5]
            end
            if (wr_seq) begin
                seq_cfg <= REG_WDATA_I & `PCR_SEQ_WMASK;
            end
            if (wr_wdt) begin
                wdt_cfg <= {1'b0, wdt_new}; // [R9]
            end
            if (wr_key) begin
                key_cfg <= REG_WDATA_I & `PCR_KEY_WMASK; // [R15]
            end
        end
    end

    // sticky flags: a new event wins over the clearing access
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            key_flag <= 1'b0;
            short_flags <= 3'h0;
        end else begin
            key_flag <= key_fire || (key_flag && !rd_key); // [R14]
            short_flags <= {SHORT_REG_SEVEN_I, SHORT_REG_FIVE_I, SHORT_OTHER_I}
                         | (wr_short ? 3'h0 : short_flags); // [R17]
        end
    end

    // read data and registered event outputs
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= `PCR_ZERO8;
            req1_prev <= 1'b0;
            REQUEST1_WAKE_O <= 1'b0;
            REQUEST2_ACTIVE_O <= 1'b0;
            REQUEST3_ACTIVE_O <= 1'b0;
            REQUEST3_LEVEL_SELECT_O <= 1'b0;
            START_ALLOWED_O <= 1'b0;
            LONG_HOLD_O <= 1'b0;
            POWER_CUT_O <= 1'b0;
        end else begin
            if (REG_RD_I) begin
                REG_RDATA_O <= rd_data;
            end
            req1_prev <= POWER_REQUEST_IN1_I;
            REQUEST1_WAKE_O <= req1_wake; // [R5]
            REQUEST2_ACTIVE_O <= POWER_REQUEST_IN2_I == pol_cfg[`PCR_BIT_REQ2_POL]; // [R4]
            REQUEST3_ACTIVE_O <= POWER_REQUEST_IN3_I == pol_cfg[`PCR_BIT_REQ3_POL]; // [R4]
            REQUEST3_LEVEL_SELECT_O <= pol_cfg[`PCR_BIT_REQ3_LEVEL];
            START_ALLOWED_O <= high_ok && VSYS_ABOVE_LOW_I; // [R7]
            LONG_HOLD_O <= long_fire; // [R15]
            POWER_CUT_O <= vlow_fire; // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // primary watchdog
    wire wd_expire = (wd_state == PCR_WD_RUN) && sec_tick && (wd_count == 7'h01); // [R11]

    always_comb begin
        next_wd_state = wd_state;
        unique case (wd_state)
            PCR_WD_HOLD: next_wd_state = POWER_ON_RESET_OUT_N_I ? PCR_WD_RUN : PCR_WD_HOLD; // [R10]
            PCR_WD_RUN: next_wd_state = POWER_ON_RESET_OUT_N_I ? PCR_WD_RUN : PCR_WD_HOLD;
            PCR_WD_OFF: next_wd_state = PCR_WD_OFF;
            default: next_wd_state = PCR_WD_HOLD;
        endcase
        if (WATCHDOG_DISABLE_I) begin
            next_wd_state = PCR_WD_OFF; // [R13]
        end else if (wd_state == PCR_WD_OFF) begin
            next_wd_state = PCR_WD_HOLD;
        end
    end

    // second ticks are free-running, so a timeout is short by up to one second
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wd_state <= PCR_WD_HOLD;
            wd_count <= 7'(`PCR_WDT_RESET);
            SWITCH_OFF_TRANSITION_O <= 1'b0;
        end else begin
            wd_state <= next_wd_state;
            SWITCH_OFF_TRANSITION_O <= wd_expire && !WATCHDOG_DISABLE_I; // [R11] [R13]
            if (wd_state != PCR_WD_RUN || wd_expire) begin
                wd_count <= wdt_field; // [R10]
            end else if (wr_wdt) begin
                wd_count <= wdt_new; // [R12]
            end else if (sec_tick) begin
                wd_count <= wd_count - 7'h01; // [R8]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // resource state, one entry per resource
    pcr_res_state_t res_state [NRES];

    for (genvar g = 0; g < NRES; g++) begin : g_res
        wire hit = (wr_all && GROUP_MEMBER_I[g]) // [R19]
                || (wr_ref && REF_MASK[g]) // [R21]
                || (wr_prov && PROV_MASK[g]); // [R22]
        // own command wins over a broadcast in the same cycle
        always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                res_state[g] <= PCR_RES_OFF;
            end else if (RES_OWN_WR_I[g]) begin
                res_state[g] <= pcr_decode(RES_OWN_CMD_I); // [R20]
            end else if (hit) begin
                res_state[g] <= bcast_state; // [R18]
            end
        end
        assign RES_STATE_O[2*g +: 2] = res_state[g]; // [R20]
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_fall1;
        req1_prev && !POWER_REQUEST_IN1_I;
    endsequence
    sequence s_rise1;
        !req1_prev && POWER_REQUEST_IN1_I;
    endsequence

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_boot_stable: assert property (!BOOT_LOAD_I |=> $stable(boot_status)) // [R2]
        else $error("boot status changed outside load");
    a_boot_pair_read: assert property (rd_boot |=> REG_RDATA_O[0] == $past(boot_status[0])) // [R3]
        else $error("threshold pair readback wrong");
    a_req3_polarity: assert property (##1 REQUEST3_ACTIVE_O == $past(POWER_REQUEST_IN3_I == pol_cfg[7])) // [R4]
        else $error("request 3 polarity wrong");
    a_wake_edge: assert property ((s_fall1 and !pol_cfg[5]) or (s_rise1 and pol_cfg[5]) |=> REQUEST1_WAKE_O) // [R5]
        else $error("wake edge missed");
    a_start_gate: assert property (##1 START_ALLOWED_O == // [R7]
        $past((seq_cfg[0] || VSYS_ABOVE_HIGH_I) && VSYS_ABOVE_LOW_I))
        else $error("start gate wrong");
    a_wdt_zero_write: assert property (wr_wdt && REG_WDATA_I[6:0] == 7'h00 |=> wdt_cfg == 8'h01) // [R9]
        else $error("zero timeout not stored as one");
    a_wdt_hold_load: assert property (wd_state == PCR_WD_HOLD |=> wd_count == $past(wdt_field)) // [R10]
        else $error("watchdog not held at timeout");
    a_wdt_expiry: assert property (wd_expire && !WATCHDOG_DISABLE_I |=> SWITCH_OFF_TRANSITION_O) // [R11]
        else $error("expiry did not switch off");
    a_wdt_disabled: assert property (WATCHDOG_DISABLE_I[*2] |-> !SWITCH_OFF_TRANSITION_O) // [R13]
        else $error("disabled watchdog fired");
    a_key_read_clear: assert property (rd_key && !key_fire |=> !key_flag) // [R14]
        else $error("hold flag not cleared by read");
    a_short_write_clear: assert property (wr_short && !SHORT_REG_SEVEN_I && !SHORT_REG_FIVE_I // [R17]
        && !SHORT_OTHER_I |=> short_flags == 3'h0)
        else $error("short flags not cleared by write");
    a_ref_only: assert property (wr_ref && RES_OWN_WR_I == '0 |=> // [R21]
        RES_STATE_O[2*NRES-1:4] == $past(RES_STATE_O[2*NRES-1:4]))
        else $error("reference broadcast touched other resources");
endmodule

// ===== sim/pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'h0;
        rd_o = 1'h0;
        wdata_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe; data inverted on release so stale bytes never match
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'h1;
        @(posedge clk_i);
        wr_o <= 1'h0;
        wdata_o <= ~d;
    endtask

    // read data is registered at the strobe edge; take it just after
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'h1;
        @(posedge clk_i);
        rd_o <= 1'h0;
        #1 d = rdata_i;
    endtask
endmodule

// ===== sim/pcr_regs_tb.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_regs_tb;
    // shortened tick so one second is sixteen clocks
    localparam int MSC = 4;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic wr, rd;
    logic [7:0] addr, wdata, rdata;
    logic boot_ld = 1'h0, in1 = 1'h0, in2 = 1'h0, in3 = 1'h0, hi = 1'h0, lo = 1'h1;
    logic por_n = 1'h0, wd_dis = 1'h0, btn = 1'h1, vlow = 1'h0, sh7 = 1'h0, sh5 = 1'h0, sho = 1'h0;
    logic [2:0] strap = 3'h0;
    logic [5:0] dly = 6'h00;
    logic [26:0] group_membership = 27'h0, own_wr = 27'h0;
    logic [1:0] own_cmd = 2'h0;
    logic wake, act2, act3, lvl, start, swoff, lhold, cut;
    logic [53:0] res;
    logic [53:0] exp_res = 54'h0;
    int fail_count = 0;
    int cmp_count = 0;

    pcr_host_model i_host (
        .clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata)
    );
    pcr_regs #(.MS_CYCLES(MSC), .MS_PER_S(4)) i_dut (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .BOOT_LOAD_I(boot_ld), .BOOT_STRAP_I(strap),
        .POWER_REQUEST_IN1_I(in1), .POWER_REQUEST_IN2_I(in2), .POWER_REQUEST_IN3_I(in3),
        .REQUEST1_WAKE_O(wake), .REQUEST2_ACTIVE_O(act2), .REQUEST3_ACTIVE_O(act3),
        .REQUEST3_LEVEL_SELECT_O(lvl), .VSYS_ABOVE_HIGH_I(hi), .VSYS_ABOVE_LOW_I(lo),
        .START_ALLOWED_O(start), .POWER_ON_RESET_OUT_N_I(por_n), .WATCHDOG_DISABLE_I(wd_dis),
        .SWITCH_OFF_TRANSITION_O(swoff), .POWER_BUTTON_IN_I(btn), .LONG_HOLD_O(lhold),
        .VSYS_LOW_I(vlow), .VSYS_LOW_DELAY_I(dly), .POWER_CUT_O(cut), .SHORT_REG_SEVEN_I(sh7),
        .SHORT_REG_FIVE_I(sh5), .SHORT_OTHER_I(sho), .GROUP_MEMBER_I(group_membership), .RES_OWN_WR_I(own_wr),
        .RES_OWN_CMD_I(own_cmd), .RES_STATE_O(res)
    );

    // free-running 40 MHz clock
    initial forever #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd8(a, d);
        chk($sformatf("reg %0h", a), d, e);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // sel: 0 wake, 1 switch-off, 2 cut, 3 long hold; a missing pulse ends the run
    task automatic wp(input int sel, input int lo_c, input int hi_c, input bit want);
        logic [3:0] v;
        for (int n = 1; n <= hi_c; n++) begin
            @(posedge clk);
            #1 v = {lhold, cut, swoff, wake};
            if (v[sel] === 1'h1) begin
                chk("pulse time", (n >= lo_c) && want, 1'h1);
                return;
            end
        end
        if (want) begin
            chk("pulse missing", 1'h0, 1'h1);
            finish_test();
        end else begin
            chk("no pulse", 1'h0, 1'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        logic [7:0] a[10] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h31, 8'h32, 8'h33, 8'h30};
        logic [7:0] e[10] = '{8'h00, 8'hE0, 8'h00, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++) begin
            rc(a[i], e[i]);
        end
        for (int i = 1; i < 5; i++) begin
            i_host.wr8(a[i], 8'hFF);
        end
        rc(8'h2A, 8'hE1);
        rc(8'h2B, 8'h03);
        rc(8'h2C, 8'h7F);
        rc(8'h2D, 8'h5F);
        i_host.wr8(8'h2C, 8'h00);
        rc(8'h2C, 8'h01);
        $display("test regs done");
    endtask

    task automatic t_boot();
        @(posedge clk);
        strap <= 3'h5;
        rc(8'h29, 8'h00);
        @(posedge clk);
        boot_ld <= 1'h1;
        @(posedge clk);
        boot_ld <= 1'h0;
        strap <= 3'h2;
        rc(8'h29, 8'h05);
        i_host.wr8(8'h29, 8'h00);
        rc(8'h29, 8'h05);
        $display("test boot done");
    endtask

    task automatic edge1(input logic v, input bit want);
        @(posedge clk);
        in1 <= v;
        wp(0, 1, 6, want);
    endtask

    task automatic t_req();
        logic [7:0] pol[2] = '{8'h01, 8'hC0};
        for (int p = 0; p < 2; p++) begin
            // polarity set before requests are relied on
            i_host.wr8(8'h2A, pol[p]);
            for (int v = 0; v < 4; v++) begin
                @(posedge clk);
                {in3, in2} <= v[1:0];
                settle();
                chk("req3", act3, in3 == pol[p][7]);
                chk("req2", act2, in2 == pol[p][6]);
            end
            chk("level", lvl, pol[p][0]);
        end
        edge1(1'h1, 1'h0);
        edge1(1'h0, 1'h1);
        i_host.wr8(8'h2A, 8'hE0);
        edge1(1'h1, 1'h1);
        edge1(1'h0, 1'h0);
        $display("test requests done");
    endtask

    task automatic t_start();
        chk("start", start, 1'h1);
        i_host.wr8(8'h2B, 8'h00);
        settle();
        chk("start", start, 1'h0);
        @(posedge clk);
        hi <= 1'h1;
        settle();
        chk("start", start, 1'h1);
        @(posedge clk);
        lo <= 1'h0;
        settle();
        chk("start", start, 1'h0);
        $display("test start done");
    endtask

    task automatic t_short();
        @(posedge clk);
        sh5 <= 1'h1;
        @(posedge clk);
        sh5 <= 1'h0;
        rc(8'h2E, 8'h02);
        @(posedge clk);
        {sh7, sho} <= 2'h3;
        @(posedge clk);
        {sh7, sho} <= 2'h0;
        rc(8'h2E, 8'h07);
        i_host.wr8(8'h2E, 8'h00);
        rc(8'h2E, 8'h00);
        $display("test shorts done");
    endtask

    // expected state follows the mask; code 10 also means off
    task automatic bc(input logic [26:0] m, input logic [1:0] c);
        for (int i = 0; i < 27; i++) begin
            if (m[i]) begin
                exp_res[2*i +: 2] = (c == 2'h2) ? 2'h0 : c;
            end
        end
        settle();
        chk("res", res, exp_res);
    endtask

    task automatic t_bcast();
        logic [1:0] c[4] = '{2'h1, 2'h3, 2'h2, 2'h1};
        for (int i = 0; i < 4; i++) begin
            i_host.wr8(8'h32, {6'h00, c[i]});
            bc(`PCR_REF_MASK, c[i]);
        end
        i_host.wr8(8'h33, 8'h03);
        bc(`PCR_PROV_MASK, 2'h3);
        @(posedge clk);
        group_membership <= 27'h4000005;
        i_host.wr8(8'h31, 8'h00);
        bc(27'h4000005, 2'h0);
        @(posedge clk);
        own_wr <= 27'h0000002;
        own_cmd <= 2'h3;
        @(posedge clk);
        own_wr <= 27'h0;
        bc(27'h0000002, 2'h3);
        $display("test broadcast done");
    endtask

    task automatic t_wdog();
        i_host.wr8(8'h2C, 8'h02);
        wp(1, 1, 100, 1'h0);
        @(posedge clk);
        por_n <= 1'h1;
        wp(1, 16, 40, 1'h1);
        for (int i = 0; i < 6; i++) begin
            // periodic refresh before expiry
            i_host.wr8(8'h2C, 8'h02);
            wp(1, 1, 12, 1'h0);
        end
        @(posedge clk);
        wd_dis <= 1'h1;
        wp(1, 1, 100, 1'h0);
        $display("test watchdog done");
    endtask

    task automatic t_cut();
        @(posedge clk);
        dly <= 6'h01;
        vlow <= 1'h1;
        wp(2, 220, 300, 1'h1);
        @(posedge clk);
        vlow <= 1'h0;
        $display("test power cut done");
    endtask

    task automatic key(input logic [4:0] code, input int ms, input bit want);
        i_host.wr8(8'h2D, {3'h2, code});
        @(posedge clk);
        btn <= 1'h0;
        repeat (ms * MSC) @(posedge clk);
        btn <= 1'h1;
        rc(8'h2D, {want, 2'h2, code});
        rc(8'h2D, {3'h2, code});
    endtask

    task automatic t_key();
        key(5'h00, 45, 1'h0);
        key(5'h00, 55, 1'h1);
        key(5'h01, 55, 1'h1);
        key(5'h02, 95, 1'h0);
        key(5'h02, 105, 1'h1);
        for (int b = 0; b < 2; b++) begin
            i_host.wr8(8'h2D, {1'h0, b[0], 6'h00});
            @(posedge clk);
            btn <= 1'h0;
            wp(3, 16000 * (b + 1) - 50, 16000 * (b + 1) + 50, 1'h1);
            @(posedge clk);
            btn <= 1'h1;
        end
        $display("test button done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_boot();
        t_req();
        t_start();
        t_short();
        t_bcast();
        t_wdog();
        t_cut();
        t_key();
        finish_test();
    end
endmodule
